// ===== rtl/port_phy_loop_and_mode_status.sv
// register bank: per-port transceiver loop, isolation and resolved mode,
// plus default vlan identifier selection for untagged traffic
// assumes single-cycle read/write strobes on both access paths, clk_sys_i domain
`timescale 1ns/1ps
// How it works
// [RL1] ports one to four each own a register, 0x10 apart; fifth slot reads zero.
// [RL2] bit seven loops the port's transceiver traffic back; zero is normal; resets zero.
// [RL3] looped port turns monitor-port frames around in its medium attachment layer.
// [RL4] bit seven in each port's register enables loopback on that port only.
// [RL5] isolation bit set disconnects the transceiver from its media interface and line.
// [RL6] bits two to zero report resolved mode with the listed codes.
// [RL7] after reset the mode field reads negotiation-in-progress until resolved.
// [RL8] default vlan identifier tags untagged egress and labels untagged ingress lookup.
// [RL9] these registers are also read and written over the management serial path.
module port_phy_loop_and_mode_status (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] acc_addr_i,
   input wire logic acc_wr_i,
   input wire logic acc_rd_i,
   input wire logic [7:0] acc_wdata_i,
   output logic [7:0] acc_rdata_o,
   output logic acc_rvalid_o,
   input wire logic [7:0] miim_addr_i,
   input wire logic miim_wr_i,
   input wire logic miim_rd_i,
   input wire logic [7:0] miim_wdata_i,
   output logic [7:0] miim_rdata_o,
   output logic miim_rvalid_o,
   input wire logic [3:0] an_done_i,
   input wire logic [3:0] speed_100_i,
   input wire logic [3:0] full_duplex_i,
   output logic [3:0] transceiver_line_return_o,
   output logic [3:0] isolate_o,
   input wire logic [47:0] default_vlan_identifier_i,
   input wire logic [1:0] ingress_port_i,
   input wire logic ingress_untagged_i,
   input wire logic [11:0] ingress_vlan_identifier_i,
   output logic [11:0] lookup_vlan_identifier_o,
   output logic [11:0] egress_tag_vlan_identifier_o
);
   logic [7:0] port_val [4];
   logic [3:0] port_wr;
   logic miim_wr_go;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] next_acc_rdata;
   logic [7:0] next_miim_rdata;
   logic [11:0] next_lookup_vlan_identifier;
   logic [11:0] next_egress_vlan_identifier;
   logic [11:0] port_vlan_identifier;

   // register-path write beats a same-cycle management write
   assign miim_wr_go = miim_wr_i && !acc_wr_i; // see [RL9]
   assign wr_addr = acc_wr_i ? acc_addr_i : miim_addr_i;
   assign wr_data = acc_wr_i ? acc_wdata_i : miim_wdata_i;

   genvar gi;
   generate
      for (gi = 0; gi < port_phy_pkg::NUM_PORTS; gi++) begin : g_port
         localparam logic [7:0] OFS = port_phy_pkg::PORT1_PHY_LOOP_MODE_STATUS
            + 8'(gi) * port_phy_pkg::REG_STRIDE;
         assign port_wr[gi] = (acc_wr_i || miim_wr_go) && (wr_addr == OFS); // see [RL1] [RL4]
         port_loop_reg u_reg (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .wr_i(port_wr[gi]),
            .wdata_i(wr_data),
            .an_done_i(an_done_i[gi]),
            .speed_100_i(speed_100_i[gi]),
            .full_duplex_i(full_duplex_i[gi]),
            .loop_o(transceiver_line_return_o[gi]), // see [RL3]
            .isolate_o(isolate_o[gi]),
            .value_o(port_val[gi])
         );
      end
   endgenerate

   function automatic logic [7:0] read_mux(input logic [7:0] addr,
         input logic [7:0] v0, input logic [7:0] v1,
         input logic [7:0] v2, input logic [7:0] v3);
      logic [7:0] r;
      r = 8'h00;
      if (addr == port_phy_pkg::PORT1_PHY_LOOP_MODE_STATUS) begin
         r = v0;
      end else if (addr == port_phy_pkg::PORT2_PHY_LOOP_MODE_STATUS) begin
         r = v1;
      end else if (addr == port_phy_pkg::PORT3_PHY_LOOP_MODE_STATUS) begin
         r = v2;
      end else if (addr == port_phy_pkg::PORT4_PHY_LOOP_MODE_STATUS) begin
         r = v3;
      end else begin
         r = 8'h00; // see [RL1]
      end
      return r;
   endfunction

   always_comb begin
      next_acc_rdata = acc_rd_i ?
         read_mux(acc_addr_i, port_val[0], port_val[1], port_val[2], port_val[3]) : acc_rdata_o;
      next_miim_rdata = miim_rd_i ?
         read_mux(miim_addr_i, port_val[0], port_val[1], port_val[2], port_val[3]) :
         miim_rdata_o; // see [RL9]
      port_vlan_identifier = default_vlan_identifier_i[
         ingress_port_i*port_phy_pkg::VLAN_IDENTIFIER_W +: port_phy_pkg::VLAN_IDENTIFIER_W];
      // untagged frames take the ingress port's default identifier
      next_lookup_vlan_identifier = ingress_untagged_i ? port_vlan_identifier :
         ingress_vlan_identifier_i; // see [RL8]
      next_egress_vlan_identifier = port_vlan_identifier; // see [RL8]
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_rdata_o <= 8'h00;
         acc_rvalid_o <= 1'b0;
         miim_rdata_o <= 8'h00;
         miim_rvalid_o <= 1'b0;
         lookup_vlan_identifier_o <= port_phy_pkg::VLAN_IDENTIFIER_RESET;
         egress_tag_vlan_identifier_o <= port_phy_pkg::VLAN_IDENTIFIER_RESET;
      end else begin
         acc_rdata_o <= next_acc_rdata;
         acc_rvalid_o <= acc_rd_i;
         miim_rdata_o <= next_miim_rdata;
         miim_rvalid_o <= miim_rd_i;
         lookup_vlan_identifier_o <= next_lookup_vlan_identifier;
         egress_tag_vlan_identifier_o <= next_egress_vlan_identifier;
      end
   end

   // control bits written over either path
   a_loop_write_port1: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL2]
      acc_wr_i && acc_addr_i == port_phy_pkg::PORT1_PHY_LOOP_MODE_STATUS
      |=> transceiver_line_return_o[0] == $past(acc_wdata_i[port_phy_pkg::LOOP_BIT]))
      else $error("port1 loop bit did not follow write");
   a_loop_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL2]
      !acc_wr_i && !miim_wr_i
      |=> $stable(transceiver_line_return_o))
      else $error("loop bits changed without a write");
   a_loop_port4_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL4]
      acc_wr_i && acc_addr_i == port_phy_pkg::PORT4_PHY_LOOP_MODE_STATUS
      |=> transceiver_line_return_o[2:0] == $past(transceiver_line_return_o[2:0]))
      else $error("port4 write disturbed other ports");
   a_isolate_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL5]
      acc_wr_i && acc_addr_i == port_phy_pkg::PORT2_PHY_LOOP_MODE_STATUS
      |=> isolate_o[1] == $past(acc_wdata_i[port_phy_pkg::ISOLATE_BIT]))
      else $error("isolation bit did not follow write");
   a_isolate_port3: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL5]
      acc_wr_i && acc_addr_i == port_phy_pkg::PORT3_PHY_LOOP_MODE_STATUS
      |=> isolate_o[2] == $past(acc_wdata_i[port_phy_pkg::ISOLATE_BIT]))
      else $error("port3 isolation bit did not follow write");
   a_reserved_write_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL1]
      acc_wr_i && !miim_wr_i && acc_addr_i == port_phy_pkg::PORT5_SLOT_RESERVED
      |=> $stable(transceiver_line_return_o) && $stable(isolate_o))
      else $error("reserved slot write changed a port");
   a_write_collision: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL9]
      acc_wr_i && miim_wr_i && acc_addr_i == port_phy_pkg::PORT2_PHY_LOOP_MODE_STATUS
      |=> isolate_o[1] == $past(acc_wdata_i[port_phy_pkg::ISOLATE_BIT]))
      else $error("register-path write lost to management write");
   a_miim_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL9]
      miim_wr_i && !acc_wr_i && miim_addr_i == port_phy_pkg::PORT2_PHY_LOOP_MODE_STATUS
      |=> transceiver_line_return_o[1] == $past(miim_wdata_i[port_phy_pkg::LOOP_BIT]))
      else $error("management write not applied");

   // read answers, one cycle after the strobe
   a_reserved_slot_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL1]
      acc_rd_i && acc_addr_i == port_phy_pkg::PORT5_SLOT_RESERVED
      |=> acc_rvalid_o && acc_rdata_o == 8'h00)
      else $error("reserved slot read not zero");
   a_read_port3: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL1]
      acc_rd_i && acc_addr_i == port_phy_pkg::PORT3_PHY_LOOP_MODE_STATUS
      |=> acc_rdata_o == $past(port_val[2]))
      else $error("port3 read data wrong");
   a_acc_rvalid_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL1]
      acc_rvalid_o == $past(acc_rd_i))
      else $error("register-path read valid not one cycle after strobe");
   a_miim_read_port2: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL9]
      miim_rd_i && miim_addr_i == port_phy_pkg::PORT2_PHY_LOOP_MODE_STATUS
      |=> miim_rvalid_o && miim_rdata_o == $past(port_val[1]))
      else $error("management read data wrong");
   a_miim_rvalid_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL9]
      miim_rvalid_o == $past(miim_rd_i))
      else $error("management read valid not one cycle after strobe");

   // resolved-mode field
   a_mode_pending: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL7]
      !an_done_i[0]
      |=> port_val[0][2:0] == port_phy_pkg::MODE_AN_BUSY)
      else $error("mode not pending while negotiating");
   a_mode_10_half: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL6]
      an_done_i[0] && !speed_100_i[0] && !full_duplex_i[0]
      |=> port_val[0][2:0] == port_phy_pkg::MODE_10_HALF)
      else $error("wrong code for 10 half duplex");
   a_mode_100_half: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL6]
      an_done_i[1] && speed_100_i[1] && !full_duplex_i[1]
      |=> port_val[1][2:0] == port_phy_pkg::MODE_100_HALF)
      else $error("wrong code for 100 half duplex");
   a_mode_10_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL6]
      an_done_i[2] && !speed_100_i[2] && full_duplex_i[2]
      |=> port_val[2][2:0] == port_phy_pkg::MODE_10_FULL)
      else $error("wrong code for 10 full duplex");
   a_mode_100_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL6]
      an_done_i[3] && speed_100_i[3] && full_duplex_i[3]
      |=> port_val[3][2:0] == port_phy_pkg::MODE_100_FULL)
      else $error("wrong code for 100 full duplex");

   // vlan identifier selection
   a_untagged_lookup: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL8]
      ingress_untagged_i && ingress_port_i == 2'h2
      |=> lookup_vlan_identifier_o == $past(default_vlan_identifier_i[35:24]))
      else $error("untagged lookup identifier wrong");
   a_tagged_lookup: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL8]
      !ingress_untagged_i
      |=> lookup_vlan_identifier_o == $past(ingress_vlan_identifier_i))
      else $error("tagged lookup identifier wrong");
   a_egress_default: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [RL8]
      ingress_port_i == 2'h2
      |=> egress_tag_vlan_identifier_o == $past(default_vlan_identifier_i[35:24]))
      else $error("egress tag identifier wrong");

   c_loop_on: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(transceiver_line_return_o[0]));
   c_isolate_on: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(isolate_o[2]));
   c_both_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      acc_wr_i && miim_wr_i);
   c_mode_resolved: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      port_val[0][2:0] == port_phy_pkg::MODE_AN_BUSY ##1
      port_val[0][2:0] == port_phy_pkg::MODE_10_HALF);
endmodule

// ===== rtl/port_phy_pkg.sv
// constants for the per-port transceiver loop / isolation / mode registers
// assumes an 8-bit register access path with byte-wide offsets
package port_phy_pkg;
   localparam int NUM_PORTS = 4;
   localparam logic [7:0] PORT1_PHY_LOOP_MODE_STATUS = 8'h1f;
   localparam logic [7:0] PORT2_PHY_LOOP_MODE_STATUS = 8'h2f;
   localparam logic [7:0] PORT3_PHY_LOOP_MODE_STATUS = 8'h3f;
   localparam logic [7:0] PORT4_PHY_LOOP_MODE_STATUS = 8'h4f;
   localparam logic [7:0] PORT5_SLOT_RESERVED = 8'h5f;
   localparam logic [7:0] REG_STRIDE = 8'h10;
   localparam int LOOP_BIT = 7;
   localparam int ISOLATE_BIT = 6;
   localparam int MODE_MSB = 2;
   localparam logic LOOP_RESET = 1'h0;
   localparam logic ISOLATE_RESET = 1'h0;
   localparam int VLAN_IDENTIFIER_W = 12;
   localparam logic [VLAN_IDENTIFIER_W-1:0] VLAN_IDENTIFIER_RESET = 12'h001;
   typedef enum logic [2:0] {
      MODE_RSVD0 = 3'b000,
      MODE_AN_BUSY = 3'b001,
      MODE_10_HALF = 3'b010,
      MODE_100_HALF = 3'b011,
      MODE_RSVD4 = 3'b100,
      MODE_10_FULL = 3'b101,
      MODE_100_FULL = 3'b110,
      MODE_RSVD7 = 3'b111
   } port_mode_t;
endpackage

// ===== rtl/port_loop_reg.sv
// one port's loop / isolation control and resolved-mode status register
// assumes transceiver status inputs are synchronous to clk_sys_i
`timescale 1ns/1ps
module port_loop_reg (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic an_done_i,
   input wire logic speed_100_i,
   input wire logic full_duplex_i,
   output logic loop_o,
   output logic isolate_o,
   output logic [7:0] value_o
);
   logic loop_q;
   logic isolate_q;
   port_phy_pkg::port_mode_t mode_q;
   logic next_loop;
   logic next_isolate;
   port_phy_pkg::port_mode_t next_mode;

   always_comb begin
      next_loop = loop_q;
      next_isolate = isolate_q;
      if (wr_i) begin
         next_loop = wdata_i[port_phy_pkg::LOOP_BIT]; // see [RL2]
         next_isolate = wdata_i[port_phy_pkg::ISOLATE_BIT]; // see [RL5]
      end
      // mode follows negotiation; reserved codes are never produced
      if (!an_done_i) begin
         next_mode = port_phy_pkg::MODE_AN_BUSY; // see [RL7]
      end else begin
         case ({speed_100_i, full_duplex_i}) // see [RL6]
            2'b00: next_mode = port_phy_pkg::MODE_10_HALF;
            2'b10: next_mode = port_phy_pkg::MODE_100_HALF;
            2'b01: next_mode = port_phy_pkg::MODE_10_FULL;
            default: next_mode = port_phy_pkg::MODE_100_FULL;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loop_q <= port_phy_pkg::LOOP_RESET;
         isolate_q <= port_phy_pkg::ISOLATE_RESET;
         mode_q <= port_phy_pkg::MODE_AN_BUSY;
      end else begin
         loop_q <= next_loop;
         isolate_q <= next_isolate;
         mode_q <= next_mode;
      end
   end

   assign loop_o = loop_q;
   assign isolate_o = isolate_q;
   assign value_o = {loop_q, isolate_q, 3'h0, mode_q};
endmodule

// ===== bench/link_partner_model.sv
// behavioural far-end link partner: resolves negotiation per port
// assumes the bench offers speed/duplex synchronously to clk_sys_i
`timescale 1ns/1ps
module link_partner_model (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [3:0] offer_i,
   input wire logic [3:0] speed_100_i,
   input wire logic [3:0] full_duplex_i,
   output logic [3:0] an_done_o,
   output logic [3:0] speed_100_o,
   output logic [3:0] full_duplex_o
);
   logic [3:0] pend;
   // ports with offer_i low show toggling speed/duplex so nothing leans on a stale value
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend <= 4'h0;
         an_done_o <= 4'h0;
         speed_100_o <= 4'h0;
         full_duplex_o <= 4'h0;
      end else begin
         pend <= offer_i;
         an_done_o <= pend & offer_i;
         speed_100_o <= (offer_i & speed_100_i) | (~offer_i & ~speed_100_o);
         full_duplex_o <= (offer_i & full_duplex_i) | (~offer_i & ~full_duplex_o);
      end
   end
endmodule

// ===== bench/port_phy_loop_and_mode_status_tb.sv
// self-checking bench for the per-port loop / isolate / mode register bank
// assumes the design's strobe-and-rvalid access on both paths
`timescale 1ns/1ps
module port_phy_loop_and_mode_status_tb;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, miim_addr = 8'h00, miim_wdata = 8'h00;
   logic acc_wr = 1'b0, acc_rd = 1'b0, miim_wr = 1'b0, miim_rd = 1'b0;
   logic [7:0] acc_rdata_o, miim_rdata_o;
   logic acc_rvalid_o, miim_rvalid_o;
   logic [3:0] offer = 4'h0, spd = 4'h0, fd = 4'h0, an_d, spd_d, fd_d, line_ret, iso;
   logic [47:0] dvid = 48'h0;
   logic [1:0] iport = 2'h0;
   logic untag = 1'b0;
   logic [11:0] ivid = 12'h0, lookup, egress;
   int n_mismatch = 0;
   int total_checks = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   link_partner_model partner (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .offer_i(offer),
      .speed_100_i(spd), .full_duplex_i(fd), .an_done_o(an_d), .speed_100_o(spd_d),
      .full_duplex_o(fd_d));
   port_phy_loop_and_mode_status dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .acc_addr_i(acc_addr), .acc_wr_i(acc_wr), .acc_rd_i(acc_rd), .acc_wdata_i(acc_wdata),
      .acc_rdata_o(acc_rdata_o), .acc_rvalid_o(acc_rvalid_o), .miim_addr_i(miim_addr),
      .miim_wr_i(miim_wr), .miim_rd_i(miim_rd), .miim_wdata_i(miim_wdata),
      .miim_rdata_o(miim_rdata_o), .miim_rvalid_o(miim_rvalid_o), .an_done_i(an_d),
      .speed_100_i(spd_d), .full_duplex_i(fd_d), .transceiver_line_return_o(line_ret),
      .isolate_o(iso), .default_vlan_identifier_i(dvid), .ingress_port_i(iport),
      .ingress_untagged_i(untag), .ingress_vlan_identifier_i(ivid),
      .lookup_vlan_identifier_o(lookup), .egress_tag_vlan_identifier_o(egress));
   task automatic conclude();
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] adr(input int p);
      return port_phy_pkg::PORT1_PHY_LOOP_MODE_STATUS + port_phy_pkg::REG_STRIDE * 8'(p);
   endfunction
   task automatic wr(input logic m, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      if (m) begin miim_addr <= a; miim_wdata <= d; miim_wr <= 1'b1; end
      else begin acc_addr <= a; acc_wdata <= d; acc_wr <= 1'b1; end
      @(posedge clk_sys_i);
      acc_wr <= 1'b0;
      miim_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic m, input logic [7:0] a, input logic [7:0] e);
      int n = 0;
      @(posedge clk_sys_i);
      if (m) begin miim_addr <= a; miim_rd <= 1'b1; end
      else begin acc_addr <= a; acc_rd <= 1'b1; end
      @(posedge clk_sys_i);
      acc_rd <= 1'b0;
      miim_rd <= 1'b0;
      #1;
      while ((m ? miim_rvalid_o : acc_rvalid_o) !== 1'b1 && n < 4) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      chk(12'(m ? miim_rvalid_o : acc_rvalid_o), 12'h1);
      chk(12'(m ? miim_rdata_o : acc_rdata_o), 12'(e));
   endtask
   // both paths strobe the same edge; the register path must win
   task automatic wr_both(input logic [7:0] a, input logic [7:0] da, input logic [7:0] dm);
      @(posedge clk_sys_i);
      acc_addr <= a;
      acc_wdata <= da;
      acc_wr <= 1'b1;
      miim_addr <= a;
      miim_wdata <= dm;
      miim_wr <= 1'b1;
      @(posedge clk_sys_i);
      acc_wr <= 1'b0;
      miim_wr <= 1'b0;
      #1;
   endtask
   initial begin
      #(3000 * 100);
      n_mismatch++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge clk_sys_i);
      chk(12'({line_ret, iso}), 12'h000);
      rst_n_i <= 1'b1;
      for (int p = 0; p < 4; p++) rd(1'b0, adr(p), 8'h01);
      for (int p = 0; p < 4; p++) begin
         wr(1'b0, adr(p), 8'h80);
         chk(12'(line_ret), 12'h001 << p);
         rd(1'b0, adr(p), 8'h81);
         wr(1'b0, adr(p), 8'h00);
      end
      chk(12'(line_ret), 12'h000);
      wr(1'b0, adr(2), 8'hff);
      chk(12'({line_ret, iso}), 12'h044);
      rd(1'b0, adr(2), 8'hc1);
      wr(1'b0, adr(2), 8'h00);
      wr(1'b0, port_phy_pkg::PORT5_SLOT_RESERVED, 8'hff);
      rd(1'b0, port_phy_pkg::PORT5_SLOT_RESERVED, 8'h00);
      chk(12'({line_ret, iso}), 12'h000);
      wr(1'b1, adr(1), 8'h80);
      rd(1'b0, adr(1), 8'h81);
      rd(1'b1, adr(1), 8'h81);
      wr_both(adr(1), 8'h00, 8'h40);
      rd(1'b1, adr(1), 8'h01);
      @(posedge clk_sys_i);
      offer <= 4'hf;
      spd <= 4'b1010;
      fd <= 4'b1100;
      repeat (6) @(posedge clk_sys_i);
      for (int p = 0; p < 4; p++) rd(p[0], adr(p), 8'(32'h06050302 >> (8 * p)));
      @(posedge clk_sys_i);
      offer <= 4'h0;
      repeat (6) @(posedge clk_sys_i);
      rd(1'b0, adr(3), 8'h01);
      @(posedge clk_sys_i);
      dvid <= {12'h444, 12'h333, 12'h222, 12'h111};
      iport <= 2'h2;
      untag <= 1'b1;
      ivid <= 12'h5a5;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(lookup, 12'h333);
      chk(egress, 12'h333);
      @(posedge clk_sys_i);
      untag <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(lookup, 12'h5a5);
      wr(1'b0, adr(3), 8'hc0);
      chk(12'({line_ret, iso}), 12'h088);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk(12'({line_ret, iso}), 12'h000);
      chk(lookup, 12'h001);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(1'b0, adr(3), 8'h01);
      chk(egress, 12'h333);
      conclude();
   end
endmodule
